// [hw/reclose_pkg.sv]
// package for the auto-reclose sequencer: register map, field positions,
// reset values, states and timing constants
// assumes a single 125 MHz system clock
package reclose_pkg;

  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DEAD1 = 8'h04;
  localparam logic [7:0] OFF_DEAD2 = 8'h08;
  localparam logic [7:0] OFF_DEAD3 = 8'h0c;
  localparam logic [7:0] OFF_DEAD4 = 8'h10;
  localparam logic [7:0] OFF_RECLAIM = 8'h14;
  localparam logic [7:0] OFF_EWAIT = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1c;
  localparam logic [7:0] OFF_CMD = 8'h20;

  // control register fields
  localparam int CTL_ENABLE = 0;
  localparam int CTL_SHOTS_LSB = 1;
  localparam int CTL_LIVEDEAD_EN = 3;
  localparam int CTL_NO_SYSCHK = 4;
  localparam int CTL_MAP_ENERGY = 5;
  localparam int CTL_MAP_PRIME = 6;
  localparam int CTL_MAP_RUN = 7;
  localparam int CTL_MAP_DONE = 8;
  localparam int CTL_REM_AUTO = 9;
  localparam int CTL_BLOCK_INST = 10;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;

  // command register fields (self clearing)
  localparam int CMD_CLEAR = 0;

  localparam logic [15:0] DEAD_RST = 16'h03e8;
  localparam logic [15:0] RECLAIM_RST = 16'h1388;
  localparam logic [15:0] EWAIT_RST = 16'h1388;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARMED,
    ST_PRIMED,
    ST_CLOSING,
    ST_RECLAIM,
    ST_LOCKOUT
  } seq_state_e;

  typedef struct packed {
    logic prot_trip;
    logic prot_pickup;
    logic ext_trip;
    logic ext_pickup;
    logic breaker_open;
    logic breaker_energy_ok;
    logic reclose_inhibit;
    logic lockout_clear;
    logic auto_mode;
    logic live_line;
    logic remote_select;
    logic live_dead_ok;
    logic system_checks_ok;
    logic delayed_reclose_done;
    logic breaker_in_use;
    logic forced_restart;
    logic priming_permit;
    logic run_permit;
    logic test_trip;
    logic shot_skip;
  } relay_in_s;

  localparam int NUM_IN = 20;

endpackage

// [hw/reclose_seq.sv]
// auto-reclose sequencer with AXI4-Lite register access
// inputs arrive from pins or other logic asynchronously and are synchronised here
//
// Overview of operation
// R01: energy low through wait interval gives lockout
// R02: unmapped energy input reads as high
// R03: inhibit blocks reclose; lockout if running
// R04: clear leaves lockout once causes gone
// R05: auto mode in service; none selected non-auto
// R06: live line out of service, unblocks, overrides
// R07: remote select takes mode from remote command
// R08: live/dead permissive used only when enabled
// R09: system checks ok or bypass allows close
// R10: external trip or pickup initiates cycle
// R11: done pulse clears secondary cycle-active only
// R12: without done, secondary follows primary exactly
// R13: breaker in use until protection operates
// R14: forced restart ignores breaker in use
// R15: priming needs open, reset protection, permit
// R16: primed state kept despite permit changes
// R17: unmapped priming permit reads as high
// R18: dead timer runs only with run permit
// R19: unmapped run permit reads as high
// R20: test trip pulse trips and starts cycle
// R21: shot skip bumps counter, lockout at last
// R22: one to four shots, own dead times
// R23: close if conditions ok, drop when closed
// R24: reprotect in reclaim advances or locks out
// R25: counter steps per trip, zero at end
// R26: inputs synchronous, intervals in timebase ticks
`timescale 1ns/1ns
module reclose_seq
  import reclose_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  input wire logic CORE_CLK_I, // system clock
  input wire logic RST_I, // synchronous reset, active high
  input wire relay_in_s RELAY_I, // relay logic inputs, asynchronous
  input wire logic [31:0] S_AXI_AWADDR_I, // write address
  input wire logic S_AXI_AWVALID_I, // write address valid
  output logic S_AXI_AWREADY_O, // write address ready
  input wire logic [31:0] S_AXI_WDATA_I, // write data
  input wire logic [3:0] S_AXI_WSTRB_I, // write strobes
  input wire logic S_AXI_WVALID_I, // write data valid
  output logic S_AXI_WREADY_O, // write data ready
  output logic [1:0] S_AXI_BRESP_O, // write response
  output logic S_AXI_BVALID_O, // write response valid
  input wire logic S_AXI_BREADY_I, // write response ready
  input wire logic [31:0] S_AXI_ARADDR_I, // read address
  input wire logic S_AXI_ARVALID_I, // read address valid
  output logic S_AXI_ARREADY_O, // read address ready
  output logic [31:0] S_AXI_RDATA_O, // read data
  output logic [1:0] S_AXI_RRESP_O, // read response
  output logic S_AXI_RVALID_O, // read data valid
  input wire logic S_AXI_RREADY_I, // read data ready
  output logic CLOSE_O, // breaker close command
  output logic TRIP_O, // breaker trip command
  output logic CYCLE_ACTIVE_PRIMARY_O, // primary cycle-active
  output logic CYCLE_ACTIVE_SECONDARY_O, // secondary cycle-active
  output logic LOCKOUT_O, // lockout status
  output logic IN_SERVICE_O, // reclosing in service
  output logic BLOCK_INST_O, // block instantaneous stages
  output logic [2:0] SHOT_COUNT_O // shot counter
);

  // two-stage synchroniser; stage one feeds only stage two
  relay_in_s meta_q, sync_q, prev_q;
  always_ff @(posedge CORE_CLK_I) begin
    meta_q <= RELAY_I;
    sync_q <= meta_q;
    prev_q <= sync_q;
  end

  // register file
  logic [31:0] ctrl_q;
  logic [15:0] dead_q [4];
  logic [15:0] reclaim_q, ewait_q;
  logic clear_cmd_q;

  // timebase tick
  logic [31:0] tick_cnt_q;
  wire tick = (tick_cnt_q == TICK_LEN - 1);
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I || tick) tick_cnt_q <= '0;
    else tick_cnt_q <= tick_cnt_q + 32'h1;
  end

  // effective inputs; unmapped energy and permits default high, an unmapped done reads low
  wire energy_ok = sync_q.breaker_energy_ok | ~ctrl_q[CTL_MAP_ENERGY]; // R02
  wire prime_ok = sync_q.priming_permit | ~ctrl_q[CTL_MAP_PRIME]; // R17
  wire run_ok = sync_q.run_permit | ~ctrl_q[CTL_MAP_RUN]; // R19
  wire done_pulse = sync_q.delayed_reclose_done & ~prev_q.delayed_reclose_done
                    & ctrl_q[CTL_MAP_DONE];
  wire test_edge = sync_q.test_trip & ~prev_q.test_trip;
  wire skip_edge = sync_q.shot_skip & ~prev_q.shot_skip;
  wire restart_edge = sync_q.forced_restart & ~prev_q.forced_restart;

  // mode selection
  wire live_line = sync_q.live_line; // R06
  wire auto_sel = sync_q.remote_select ? ctrl_q[CTL_REM_AUTO] : sync_q.auto_mode; // R07
  wire in_service = ctrl_q[CTL_ENABLE] & ~live_line & auto_sel; // R05 R06
  wire [2:0] max_shots = {1'b0, ctrl_q[CTL_SHOTS_LSB +: 2]} + 3'h1; // R22

  wire prot_op = sync_q.prot_trip | sync_q.ext_trip | sync_q.prot_pickup
                 | sync_q.ext_pickup; // R10
  wire prot_trip_any = sync_q.prot_trip | sync_q.ext_trip;
  wire prot_reset = ~prot_op;
  wire prot_edge = prot_op & ~(prev_q.prot_trip | prev_q.ext_trip
                   | prev_q.prot_pickup | prev_q.ext_pickup);
  // breaker must have been in use up to the sample before operation
  wire init_ok = prot_edge & prev_q.breaker_in_use; // R13
  wire initiate = in_service & ~sync_q.reclose_inhibit
                  & (init_ok | restart_edge | test_edge); // R14 R20
  wire sys_ok = (sync_q.system_checks_ok | ctrl_q[CTL_NO_SYSCHK]) // R09
                & (sync_q.live_dead_ok | ~ctrl_q[CTL_LIVEDEAD_EN]); // R08

  seq_state_e state_q, state_d;
  logic [15:0] timer_q, timer_d;
  logic [2:0] shot_q, shot_d;
  logic [15:0] ewait_cnt_q, ewait_cnt_d;
  logic sec_q, sec_d, trip_q, trip_d, close_q, close_d;
  logic lock_energy_q, lock_energy_d;

  // the counter holds one during the first dead time, so attempt n uses dead time n
  wire [1:0] dead_idx = shot_q[1:0] - 2'h1;
  wire [15:0] dead_sel = dead_q[dead_idx]; // R22
  wire active = (state_q != ST_IDLE) && (state_q != ST_LOCKOUT);

  always_comb begin
    state_d = state_q;
    timer_d = timer_q;
    shot_d = shot_q;
    ewait_cnt_d = ewait_cnt_q;
    sec_d = sec_q;
    trip_d = test_edge & in_service; // R20
    close_d = 1'b0;
    lock_energy_d = lock_energy_q;
    case (state_q)
      ST_IDLE: begin
        shot_d = 3'h0;
        if (initiate) begin
          state_d = ST_ARMED;
          sec_d = 1'b1;
          shot_d = 3'h1; // R25
        end
      end
      ST_ARMED: begin
        timer_d = 16'h0;
        if (sync_q.breaker_open && prot_reset && prime_ok) state_d = ST_PRIMED; // R15
      end
      ST_PRIMED: begin
        // primed stays regardless of the priming permit
        if (!(sync_q.breaker_open && prot_reset && run_ok)) begin // R16 R18
          timer_d = 16'h0;
        end else if (timer_q >= dead_sel) begin
          state_d = ST_CLOSING;
          ewait_cnt_d = 16'h0;
        end else if (tick) begin
          timer_d = timer_q + 16'h1; // R26
        end
      end
      ST_CLOSING: begin
        if (!sync_q.breaker_open) begin
          state_d = ST_RECLAIM; // R23
          timer_d = 16'h0;
        end else if (energy_ok && sys_ok) begin
          close_d = 1'b1; // R23
          ewait_cnt_d = 16'h0;
        end else if (!energy_ok) begin
          if (ewait_cnt_q >= ewait_q) begin
            state_d = ST_LOCKOUT; // R01
            lock_energy_d = 1'b1;
          end else if (tick) begin
            ewait_cnt_d = ewait_cnt_q + 16'h1;
          end
        end
      end
      ST_RECLAIM: begin
        if (prot_trip_any) begin
          if (shot_q >= max_shots) state_d = ST_LOCKOUT; // R24
          else state_d = ST_ARMED;
          shot_d = shot_q + 3'h1; // R25
        end else if (timer_q >= reclaim_q) begin
          state_d = ST_IDLE; // R25
          sec_d = 1'b0;
          shot_d = 3'h0;
        end else if (tick) begin
          timer_d = timer_q + 16'h1;
        end
      end
      ST_LOCKOUT: begin
        sec_d = 1'b0;
        close_d = 1'b0;
        if (clear_cmd_q && !sync_q.reclose_inhibit && prot_reset && energy_ok) begin // R04
          state_d = ST_IDLE;
          lock_energy_d = 1'b0;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (active && skip_edge) begin
      if (shot_q >= max_shots) state_d = ST_LOCKOUT; // R21
      shot_d = shot_q + 3'h1; // R21
    end
    if (active && (sync_q.reclose_inhibit || !in_service)) begin
      state_d = ST_LOCKOUT; // R03
      close_d = 1'b0;
    end
    // a skip can end the cycle while closing; never leave a close standing in lockout
    if (state_d == ST_LOCKOUT) close_d = 1'b0;
    if (active && done_pulse) sec_d = 1'b0; // R11
    if (state_d == ST_IDLE || state_d == ST_LOCKOUT) sec_d = 1'b0; // R12
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      state_q <= ST_IDLE;
      timer_q <= 16'h0;
      shot_q <= 3'h0;
      ewait_cnt_q <= 16'h0;
      sec_q <= 1'b0;
      trip_q <= 1'b0;
      close_q <= 1'b0;
      lock_energy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      shot_q <= shot_d;
      ewait_cnt_q <= ewait_cnt_d;
      sec_q <= sec_d;
      trip_q <= trip_d;
      close_q <= close_d;
      lock_energy_q <= lock_energy_d;
    end
  end

  // outputs, all registered
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      CLOSE_O <= 1'b0;
      TRIP_O <= 1'b0;
      CYCLE_ACTIVE_PRIMARY_O <= 1'b0;
      CYCLE_ACTIVE_SECONDARY_O <= 1'b0;
      LOCKOUT_O <= 1'b0;
      IN_SERVICE_O <= 1'b0;
      BLOCK_INST_O <= 1'b0;
      SHOT_COUNT_O <= 3'h0;
    end else begin
      CLOSE_O <= close_d;
      TRIP_O <= trip_d;
      CYCLE_ACTIVE_PRIMARY_O <= (state_d != ST_IDLE) && (state_d != ST_LOCKOUT);
      CYCLE_ACTIVE_SECONDARY_O <= sec_d; // R12
      LOCKOUT_O <= (state_d == ST_LOCKOUT);
      IN_SERVICE_O <= in_service;
      BLOCK_INST_O <= ctrl_q[CTL_BLOCK_INST] & ~live_line; // R06
      SHOT_COUNT_O <= shot_d;
    end
  end

  // AXI4-Lite slave: address and data latched independently
  logic aw_have_q, w_have_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= OFF_CMD);
  endfunction

  wire do_write = aw_have_q && w_have_q && !S_AXI_BVALID_O;
  wire [31:0] wr_val = merge(32'h0, w_data_q, w_strb_q);
  wire [31:0] status_word = {24'h0, lock_energy_q, shot_q, 1'b0, state_q};

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      S_AXI_AWREADY_O <= 1'b0;
      S_AXI_WREADY_O <= 1'b0;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= 2'b00;
    end else begin
      S_AXI_AWREADY_O <= !aw_have_q && !S_AXI_AWREADY_O;
      S_AXI_WREADY_O <= !w_have_q && !S_AXI_WREADY_O;
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR_I[7:0];
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_have_q <= 1'b1;
        w_data_q <= S_AXI_WDATA_I;
        w_strb_q <= S_AXI_WSTRB_I;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O <= (mapped(aw_addr_q) && aw_addr_q != OFF_STATUS) ? 2'b00 : 2'b10;
      end else if (S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      ctrl_q <= CTRL_RST;
      for (int i = 0; i < 4; i++) dead_q[i] <= DEAD_RST;
      reclaim_q <= RECLAIM_RST;
      ewait_q <= EWAIT_RST;
      clear_cmd_q <= 1'b0;
    end else begin
      clear_cmd_q <= sync_q.lockout_clear;
      if (do_write) begin
        case (aw_addr_q)
          OFF_CTRL: ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q);
          OFF_DEAD1: dead_q[0] <= wr_val[15:0];
          OFF_DEAD2: dead_q[1] <= wr_val[15:0];
          OFF_DEAD3: dead_q[2] <= wr_val[15:0];
          OFF_DEAD4: dead_q[3] <= wr_val[15:0];
          OFF_RECLAIM: reclaim_q <= wr_val[15:0];
          OFF_EWAIT: ewait_q <= wr_val[15:0];
          OFF_CMD: clear_cmd_q <= wr_val[CMD_CLEAR] | sync_q.lockout_clear;
          default: ;
        endcase
      end
    end
  end

  wire ar_take = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  wire [7:0] ar_a = S_AXI_ARADDR_I[7:0];
  wire [31:0] rd_val =
    (ar_a == OFF_CTRL) ? ctrl_q :
    (ar_a == OFF_DEAD1) ? {16'h0, dead_q[0]} :
    (ar_a == OFF_DEAD2) ? {16'h0, dead_q[1]} :
    (ar_a == OFF_DEAD3) ? {16'h0, dead_q[2]} :
    (ar_a == OFF_DEAD4) ? {16'h0, dead_q[3]} :
    (ar_a == OFF_RECLAIM) ? {16'h0, reclaim_q} :
    (ar_a == OFF_EWAIT) ? {16'h0, ewait_q} :
    (ar_a == OFF_STATUS) ? status_word : 32'h0;

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h0;
      S_AXI_RRESP_O <= 2'b00;
    end else begin
      S_AXI_ARREADY_O <= !S_AXI_RVALID_O && !S_AXI_ARREADY_O;
      if (ar_take) begin
        S_AXI_ARREADY_O <= 1'b0;
        S_AXI_RVALID_O <= 1'b1;
        S_AXI_RDATA_O <= rd_val;
        S_AXI_RRESP_O <= mapped(ar_a) ? 2'b00 : 2'b10;
      end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
        S_AXI_RVALID_O <= 1'b0;
      end
    end
  end

endmodule

// [dv/breaker_model.sv]
// breaker model for the sequencer bench: opens on a trip, closes on a close
// assumes both commands are levels on the system clock
`timescale 1ns/1ns
module breaker_model #(
  parameter int DLY = 3
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // reset, active high
  input wire logic trip_i, // any trip command
  input wire logic close_i, // close command
  output logic open_o, // breaker open
  output logic in_use_o // breaker in service
);
  logic want_q;
  int cnt_q;
  // in service only while closed, right up to the trip that opens it
  assign in_use_o = !open_o;
  // travel takes DLY+1 cycles after the command is sampled; a trip beats a close
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      open_o <= 1'b0;
      want_q <= 1'b0;
      cnt_q <= 0;
    end else begin
      if (trip_i) want_q <= 1'b1;
      else if (close_i) want_q <= 1'b0;
      cnt_q <= (want_q != open_o) ? cnt_q + 1 : 0;
      if (cnt_q == DLY) open_o <= want_q;
    end
  end
endmodule

// [dv/reclose_seq_sva.sv]
// port checker for the reclose sequencer
// assumes relay inputs are held several cycles at a time
`timescale 1ns/1ns
module reclose_seq_sva
  import reclose_pkg::*;
(
  input wire logic CORE_CLK_I, // clock
  input wire logic RST_I, // reset
  input wire relay_in_s RELAY_I, // relay inputs
  input wire logic CLOSE_O, // close
  input wire logic TRIP_O, // trip
  input wire logic CYCLE_ACTIVE_PRIMARY_O, // primary
  input wire logic CYCLE_ACTIVE_SECONDARY_O, // secondary
  input wire logic LOCKOUT_O, // lockout
  input wire logic IN_SERVICE_O, // in service
  input wire logic BLOCK_INST_O, // block inst
  input wire logic [2:0] SHOT_COUNT_O // shot counter
);
  default clocking @(posedge CORE_CLK_I);
  endclocking
  default disable iff (RST_I);
  // eight cycles cover the synchroniser and the output register
  property p_inhibit;
    RELAY_I.reclose_inhibit [*8] |-> !CYCLE_ACTIVE_PRIMARY_O && !CLOSE_O;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("cycle while inhibited");
  property p_non_auto;
    (!RELAY_I.auto_mode && !RELAY_I.live_line && !RELAY_I.remote_select) [*8]
      |-> !IN_SERVICE_O;
  endproperty
  a_non_auto: assert property (p_non_auto) else $error("in service in non-auto");
  property p_live;
    RELAY_I.live_line [*8] |-> !IN_SERVICE_O && !BLOCK_INST_O;
  endproperty
  a_live: assert property (p_live) else $error("live line not honoured");
  property p_sec;
    CYCLE_ACTIVE_SECONDARY_O |-> CYCLE_ACTIVE_PRIMARY_O;
  endproperty
  a_sec: assert property (p_sec) else $error("secondary without primary");
  property p_sec_set;
    $rose(CYCLE_ACTIVE_PRIMARY_O) |-> CYCLE_ACTIVE_SECONDARY_O;
  endproperty
  a_sec_set: assert property (p_sec_set) else $error("secondary late");
  property p_test;
    $rose(RELAY_I.test_trip) |-> ##[1:6] TRIP_O;
  endproperty
  a_test: assert property (p_test) else $error("no test trip");
  property p_close_drop;
    !RELAY_I.breaker_open [*8] |-> !CLOSE_O;
  endproperty
  a_close_drop: assert property (p_close_drop) else $error("close held");
  property p_close_lock;
    CLOSE_O |-> !LOCKOUT_O;
  endproperty
  a_close_lock: assert property (p_close_lock) else $error("close in lockout");
  property p_shot_step;
    $changed(SHOT_COUNT_O) |-> SHOT_COUNT_O == $past(SHOT_COUNT_O) + 3'h1 || SHOT_COUNT_O == 3'h0;
  endproperty
  a_shot_step: assert property (p_shot_step) else $error("shot step");
  property p_shot_end;
    $fell(CYCLE_ACTIVE_PRIMARY_O) ##2 !LOCKOUT_O |-> SHOT_COUNT_O == 3'h0;
  endproperty
  a_shot_end: assert property (p_shot_end) else $error("shot not cleared");
  property p_lock_idle;
    LOCKOUT_O [*2] |-> !CYCLE_ACTIVE_PRIMARY_O;
  endproperty
  a_lock_idle: assert property (p_lock_idle) else $error("active in lockout");
  c_close: cover property ($rose(CLOSE_O));
  c_lock: cover property ($rose(LOCKOUT_O));
  c_sec: cover property ($fell(CYCLE_ACTIVE_SECONDARY_O) && CYCLE_ACTIVE_PRIMARY_O);
endmodule
bind reclose_seq reclose_seq_sva u_sva (.CORE_CLK_I, .RST_I, .RELAY_I, .CLOSE_O, .TRIP_O,
  .CYCLE_ACTIVE_PRIMARY_O, .CYCLE_ACTIVE_SECONDARY_O, .LOCKOUT_O, .IN_SERVICE_O,
  .BLOCK_INST_O, .SHOT_COUNT_O);

// [dv/reclose_seq_test.sv]
// bench for the reclose sequencer: AXI4-Lite master, relay inputs, breaker model
// assumes the design, breaker_model and the checker are compiled first
`timescale 1ns/1ns
module reclose_seq_test
  import reclose_pkg::*;
;
  localparam int CL = 6, TR = 5, PR = 4, SE = 3, LK = 2, IS = 1;
  localparam relay_in_s M_EXT = '{ext_trip: 1'b1, default: 1'b0};
  localparam relay_in_s M_SKIP = '{shot_skip: 1'b1, default: 1'b0};
  localparam relay_in_s M_DONE = '{delayed_reclose_done: 1'b1, default: 1'b0};
  localparam relay_in_s M_RST = '{forced_restart: 1'b1, default: 1'b0};
  logic clk = 1'b0, rst = 1'b1, bo, iu;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [7:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, d;
  logic [1:0] r;
  relay_in_s rin, rel;
  wire [31:0] rdata;
  wire [1:0] bresp, rresp;
  wire awr, wr_rdy, bv, arr, rv;
  wire [6:0] o;
  wire [2:0] shot;
  int error_cnt = 0, num_checks = 0, cyc_n = 0;

  always #4 clk = ~clk;
  always_comb begin
    rel = rin;
    rel.breaker_open = bo;
    rel.breaker_in_use = iu;
  end

  reclose_seq #(.TICK_LEN(10)) u_dut (
    .CORE_CLK_I(clk), .RST_I(rst), .RELAY_I(rel),
    .S_AXI_AWADDR_I({24'h0, awa}), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
    .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr_rdy),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br),
    .S_AXI_ARADDR_I({24'h0, ara}), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr),
    .CLOSE_O(o[6]), .TRIP_O(o[5]), .CYCLE_ACTIVE_PRIMARY_O(o[4]),
    .CYCLE_ACTIVE_SECONDARY_O(o[3]), .LOCKOUT_O(o[2]), .IN_SERVICE_O(o[1]),
    .BLOCK_INST_O(o[0]), .SHOT_COUNT_O(shot));

  breaker_model u_cb (.clk_i(clk), .rst_i(rst), .trip_i(o[TR] | rin.ext_trip),
    .close_i(o[CL]), .open_o(bo), .in_use_o(iu));

  task results;
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 30000) begin
      error_cnt++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // bounded wait for one output level, then judge it
  task automatic wt(input int b, input logic v, input int n);
    for (int i = 0; i < n && o[b] !== v; i++) @(posedge clk);
    chk(o[b], v);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dv);
    awa <= a;
    wd <= dv;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
    end while (!bv);
    r = bresp;
    br <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    d = rdata;
    r = rresp;
    rr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic pls(input relay_in_s m);
    rin <= rin | m;
    cyc(4);
    rin <= rin & ~m;
    cyc(4);
  endtask

  task automatic t_regs;
    rd(OFF_CTRL);
    chk(d, CTRL_RST);
    rd(OFF_DEAD3);
    chk(d, {16'h0, DEAD_RST});
    rd(OFF_EWAIT);
    chk(d, {16'h0, EWAIT_RST});
    rd(8'h40);
    chk(r, 2'b10);
    chk(d, 32'h0);
    wr(OFF_STATUS, 32'h7);
    chk(r, 2'b10);
    for (int i = 0; i < 4; i++) wr(OFF_DEAD1 + 8'(4 * i), 32'h4);
    wr(OFF_RECLAIM, 32'h1e);
    wr(OFF_EWAIT, 32'h5);
    wr(OFF_CTRL, 32'h3);
    rd(OFF_DEAD4);
    chk(d, 32'h4);
  endtask

  task automatic t_modes;
    rin.auto_mode <= 1'b0;
    cyc(8);
    chk(o[IS], 1'b0);
    rin.remote_select <= 1'b1;
    wr(OFF_CTRL, 32'h203);
    cyc(8);
    chk(o[IS], 1'b1);
    rin.auto_mode <= 1'b1;
    wr(OFF_CTRL, 32'h403);
    cyc(8);
    chk(o[IS], 1'b0);
    chk(o[0], 1'b1);
    rin.remote_select <= 1'b0;
    rin.live_line <= 1'b1;
    cyc(8);
    chk(o[IS], 1'b0);
    chk(o[0], 1'b0);
    rin.live_line <= 1'b0;
    wr(OFF_CTRL, 32'h3);
    cyc(8);
    chk(o[IS], 1'b1);
  endtask

  task automatic t_cycle;
    pls(M_EXT);
    wt(PR, 1'b1, 20);
    chk(o[SE], 1'b1);
    chk(shot, 3'h1);
    wt(CL, 1'b1, 200);
    wt(CL, 1'b0, 30);
    wt(PR, 1'b0, 500);
    chk(o[SE], 1'b0);
    chk(shot, 3'h0);
  endtask

  task automatic t_done;
    wr(OFF_CTRL, 32'h103);
    pls(M_EXT);
    wt(CL, 1'b1, 200);
    pls(M_DONE);
    wt(SE, 1'b0, 10);
    chk(o[PR], 1'b1);
    wt(PR, 1'b0, 500);
    wr(OFF_CTRL, 32'h3);
  endtask

  task automatic t_test;
    rin.test_trip <= 1'b1;
    wt(TR, 1'b1, 8);
    rin.test_trip <= 1'b0;
    wt(PR, 1'b1, 10);
    wt(CL, 1'b1, 200);
    wt(PR, 1'b0, 600);
  endtask

  // lockout clear is refused while the inhibit stands, then a restart on an open breaker
  task automatic t_inhibit;
    pls(M_EXT);
    rin.reclose_inhibit <= 1'b1;
    wt(LK, 1'b1, 20);
    cyc(2);
    chk(o[PR], 1'b0);
    wr(OFF_CMD, 32'h1);
    cyc(4);
    chk(o[LK], 1'b1);
    rin.reclose_inhibit <= 1'b0;
    cyc(6);
    wr(OFF_CMD, 32'h1);
    wt(LK, 1'b0, 10);
    pls(M_RST);
    wt(PR, 1'b1, 10);
    wt(CL, 1'b1, 200);
    wt(PR, 1'b0, 600);
  endtask

  // a trip in reclaim takes the next shot; the close waits for system checks
  task automatic t_reclaim;
    pls(M_EXT);
    wt(CL, 1'b1, 200);
    wt(CL, 1'b0, 30);
    pls(M_EXT);
    chk(shot, 3'h2);
    rin.system_checks_ok <= 1'b0;
    cyc(120);
    chk(o[CL], 1'b0);
    rin.system_checks_ok <= 1'b1;
    wt(CL, 1'b1, 20);
    wt(CL, 1'b0, 30);
    pls(M_EXT);
    wt(LK, 1'b1, 20);
    wr(OFF_CMD, 32'h1);
    wt(LK, 1'b0, 10);
    pls(M_RST);
    wt(PR, 1'b0, 600);
  endtask

  task automatic t_skip;
    wr(OFF_CTRL, 32'h7);
    pls(M_EXT);
    chk(shot, 3'h1);
    pls(M_SKIP);
    chk(shot, 3'h2);
    wt(PR, 1'b0, 800);
    wr(OFF_CTRL, 32'h1);
    pls(M_EXT);
    pls(M_SKIP);
    wt(LK, 1'b1, 20);
    wr(OFF_CMD, 32'h1);
    wt(LK, 1'b0, 10);
    wr(OFF_CTRL, 32'h3);
  endtask

  task automatic t_energy;
    rin.breaker_energy_ok <= 1'b0;
    cyc(1);
    pls(M_RST);
    wt(CL, 1'b1, 200);
    wt(PR, 1'b0, 600);
    wr(OFF_CTRL, 32'h23);
    pls(M_EXT);
    wt(LK, 1'b1, 300);
    chk(o[CL], 1'b0);
    chk(bo, 1'b1);
  endtask

  initial begin
    rin = '{auto_mode: 1'b1, breaker_energy_ok: 1'b1, system_checks_ok: 1'b1,
      live_dead_ok: 1'b1, priming_permit: 1'b1, run_permit: 1'b1, default: 1'b0};
    cyc(12);
    rst <= 1'b0;
    cyc(4);
    t_regs();
    t_modes();
    t_cycle();
    t_done();
    t_test();
    t_inhibit();
    t_reclaim();
    t_skip();
    t_energy();
    results();
  end
endmodule
